// ### pkg/dpd_cfg.svh
`ifndef DPD_CFG_SVH
`define DPD_CFG_SVH

// Serial instruction codes
`define DPD_OP_ENTER 8'hb9
`define DPD_OP_EXIT 8'hab
`define DPD_OP_RDSR 8'h05
`define DPD_OP_SFDP 8'h5a

// Parameter word fields, bit 31 down to bit 0
`define DPD_FLD_NOT_SUPP 1'h0
`define DPD_FLD_UNIT 2'h1
`define DPD_FLD_COUNT 5'h02
`define DPD_FLD_RFU_HI 4'hf
`define DPD_FLD_POLL 2'h1
`define DPD_FLD_RFU_LO 2'h3
`define DPD_SFDP_DW14_ADDR 24'h000034
`define DPD_SFDP_FILL 8'hff

// Timing: unit code 01b means 1 us
`define DPD_CLK_NS 100
`define DPD_WAKE_UNIT_NS 1000
`define DPD_WAKE_COUNT 2
`define DPD_WAKE_NS ((`DPD_WAKE_COUNT + 1) * `DPD_WAKE_UNIT_NS)
`define DPD_WAKE_W 8

// APB register map (byte addresses)
`define DPD_REG_CTRL 12'h000
`define DPD_REG_STATUS 12'h004
`define DPD_REG_INT_STAT 12'h008
`define DPD_REG_INT_CLR 12'h00c
`define DPD_REG_INT_EN 12'h010
`define DPD_REG_LAST_CMD 12'h014

// Interrupt bit positions
`define DPD_INT_ENTER 0
`define DPD_INT_EXIT 1
`define DPD_INT_WAKE 2
`define DPD_INT_IGNORED 3
`define DPD_INT_W 4

`endif

// ### pkg/dpd_pkg.sv
`include "dpd_cfg.svh"

package dpd_pkg;

   typedef enum logic [2:0] {
      DPD_PH_IDLE,
      DPD_PH_CMD,
      DPD_PH_ADDR,
      DPD_PH_DUMMY,
      DPD_PH_DATA,
      DPD_PH_HOLD,
      DPD_PH_IGNORE
   } dpd_phase_t;

   typedef struct packed {
      logic sclk_d;
      logic cs_n_d;
      dpd_phase_t phase;
      logic [4:0] bitcnt;
      logic [7:0] shin;
      logic [23:0] addr;
      logic [7:0] obyte;
      logic [2:0] ocnt;
      logic is_sfdp;
      logic pend_enter;
      logic pend_exit;
      logic dpd;
      logic [`DPD_WAKE_W-1:0] wake_cnt;
      logic sw_busy;
      logic [`DPD_INT_W-1:0] int_stat;
      logic [`DPD_INT_W-1:0] int_en;
      logic [7:0] last_cmd;
      logic miso;
      logic miso_oe;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dpd_state_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } dpd_pins_t;

endpackage : dpd_pkg

// ### rtl/dpd_sync.sv
module dpd_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule : dpd_sync

// ### rtl/dpd_top.sv
// Notes on behaviour
// - Instruction b9h in a one-byte frame enters deep power-down; b9h sits in word bits 30:23.
// - Instruction abh leaves deep power-down, and abh sits in bits 22:15 of the parameter word.
// - The wake-up delay advertises unit 01b (1 us) and count 00010b, giving (count+1)*unit.
// - Reading status with 05h returns a byte whose bit 0 is high while busy and low when ready.
// - Bit 31 of the parameter word is zero to show that deep power-down is supported.
// - Parameter-area bytes 34h to 37h read back as f7h, a2h, d5h and 5ch.
`include "dpd_cfg.svh"

module dpd_top
   import dpd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   output logic power_down,
   output logic irq
);

   // Wake-up time is derived from DPD_WAKE_COUNT and DPD_WAKE_UNIT_NS, defined apart from the advertised fields
   localparam int WAKE_CYC = (`DPD_WAKE_NS + `DPD_CLK_NS - 1) / `DPD_CLK_NS;
   localparam logic [`DPD_WAKE_W-1:0] WAKE_LOAD = WAKE_CYC[`DPD_WAKE_W-1:0];
   localparam logic [31:0] DW14 = {`DPD_FLD_NOT_SUPP, `DPD_OP_ENTER, `DPD_OP_EXIT,
      `DPD_FLD_UNIT, `DPD_FLD_COUNT, `DPD_FLD_RFU_HI, `DPD_FLD_POLL,
      `DPD_FLD_RFU_LO};

   dpd_pins_t pins_raw;
   dpd_pins_t pins_s;
   dpd_state_t r;
   dpd_state_t s;

   assign pins_raw = '{sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};

   // Pins are sampled, so the serial clock must stay below a quarter of pclk
   dpd_sync #(
      .WIDTH(3),
      .INIT(3'h2)
   ) u_pin_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(pins_raw),
      .q(pins_s)
   );

   function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
      logic [7:0] b;
      b = `DPD_SFDP_FILL;
      if ({a[23:2], 2'h0} == `DPD_SFDP_DW14_ADDR) begin
         unique case (a[1:0])
            2'h0: b = DW14[7:0];
            2'h1: b = DW14[15:8];
            2'h2: b = DW14[23:16];
            2'h3: b = DW14[31:24];
         endcase
      end
      return b;
   endfunction : sfdp_byte

   logic busy;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic [7:0] cmd_byte;
   logic [`DPD_INT_W-1:0] ev;
   logic [31:0] rd_val;
   logic rd_ok;
   logic acc;

   always_comb begin
      s = r;
      ev = '0;
      busy = r.sw_busy | (r.wake_cnt != '0);
      sclk_rise = pins_s.sclk & ~r.sclk_d;
      sclk_fall = ~pins_s.sclk & r.sclk_d;
      cs_fall = ~pins_s.cs_n & r.cs_n_d;
      cs_rise = pins_s.cs_n & ~r.cs_n_d;
      cmd_byte = {r.shin[6:0], pins_s.mosi};
      s.sclk_d = pins_s.sclk;
      s.cs_n_d = pins_s.cs_n;

      if (r.wake_cnt != '0) begin
         s.wake_cnt = r.wake_cnt - 1'b1;
         if (r.wake_cnt == `DPD_WAKE_W'(1)) begin
            ev[`DPD_INT_WAKE] = 1'b1;
         end
      end

      // Serial side
      if (cs_rise) begin
         if (r.pend_enter) begin
            s.dpd = 1'b1;
            ev[`DPD_INT_ENTER] = 1'b1;
         end
         if (r.pend_exit) begin
            s.dpd = 1'b0;
            s.wake_cnt = WAKE_LOAD;
            ev[`DPD_INT_EXIT] = 1'b1;
         end
         s.phase = DPD_PH_IDLE;
         s.pend_enter = 1'b0;
         s.pend_exit = 1'b0;
         s.miso_oe = 1'b0;
      end else if (cs_fall) begin
         s.phase = DPD_PH_CMD;
         s.bitcnt = '0;
         s.pend_enter = 1'b0;
         s.pend_exit = 1'b0;
      end else if (!pins_s.cs_n && sclk_rise) begin
         unique case (r.phase)
            DPD_PH_CMD: begin
               s.shin = cmd_byte;
               s.bitcnt = r.bitcnt + 1'b1;
               if (r.bitcnt == 5'h07) begin
                  s.last_cmd = cmd_byte;
                  s.bitcnt = '0;
                  s.phase = DPD_PH_IGNORE;
                  if (r.dpd) begin
                     if (cmd_byte == `DPD_OP_EXIT) begin
                        s.pend_exit = 1'b1;
                        s.phase = DPD_PH_HOLD;
                     end else begin
                        ev[`DPD_INT_IGNORED] = 1'b1;
                     end
                  end else if (cmd_byte == `DPD_OP_ENTER) begin
                     s.pend_enter = 1'b1;
                     s.phase = DPD_PH_HOLD;
                  end else if (cmd_byte == `DPD_OP_RDSR) begin
                     s.phase = DPD_PH_DATA;
                     s.is_sfdp = 1'b0;
                     s.ocnt = '0;
                     s.obyte = {7'h00, busy};
                  end else if (cmd_byte == `DPD_OP_SFDP) begin
                     s.phase = DPD_PH_ADDR;
                     s.is_sfdp = 1'b1;
                  end
               end
            end
            DPD_PH_ADDR: begin
               s.addr = {r.addr[22:0], pins_s.mosi};
               s.bitcnt = r.bitcnt + 1'b1;
               if (r.bitcnt == 5'h17) begin
                  s.bitcnt = '0;
                  s.phase = DPD_PH_DUMMY;
               end
            end
            DPD_PH_DUMMY: begin
               s.bitcnt = r.bitcnt + 1'b1;
               if (r.bitcnt == 5'h07) begin
                  s.phase = DPD_PH_DATA;
                  s.ocnt = '0;
                  s.obyte = sfdp_byte(r.addr);
               end
            end
            DPD_PH_HOLD: begin
               // Extra clocks after a one-byte command cancel it
               s.pend_enter = 1'b0;
               s.pend_exit = 1'b0;
               s.phase = DPD_PH_IGNORE;
            end
            default: begin
            end
         endcase
      end else if (!pins_s.cs_n && sclk_fall && r.phase == DPD_PH_DATA) begin
         s.miso_oe = ~r.dpd;
         s.miso = r.obyte[3'h7 - r.ocnt];
         s.ocnt = r.ocnt + 1'b1;
         if (r.ocnt == 3'h7) begin
            if (r.is_sfdp) begin
               s.addr = r.addr + 1'b1;
               s.obyte = sfdp_byte(r.addr + 24'h000001);
            end else begin
               s.obyte = {7'h00, busy};
            end
         end
      end
      if (s.dpd) begin
         s.miso_oe = 1'b0;
      end

      // APB slave: answer in the first access cycle
      rd_ok = 1'b1;
      unique case (paddr)
         `DPD_REG_CTRL: rd_val = {31'h00000000, r.sw_busy};
         `DPD_REG_STATUS: rd_val = {29'h00000000, r.wake_cnt != '0, busy, r.dpd};
         `DPD_REG_INT_STAT: rd_val = {28'h0000000, r.int_stat};
         `DPD_REG_INT_CLR: rd_val = 32'h00000000;
         `DPD_REG_INT_EN: rd_val = {28'h0000000, r.int_en};
         `DPD_REG_LAST_CMD: rd_val = {24'h000000, r.last_cmd};
         default: begin
            rd_val = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
      acc = psel & penable & r.pready;
      s.pready = psel & ~penable;
      s.pslverr = psel & ~penable & ~rd_ok;
      if (psel && !penable) begin
         s.prdata = pwrite ? 32'h00000000 : rd_val;
      end
      s.int_stat = r.int_stat;
      if (acc && pwrite) begin
         unique case (paddr)
            `DPD_REG_CTRL: s.sw_busy = pwdata[0];
            `DPD_REG_INT_CLR: s.int_stat = r.int_stat & ~pwdata[`DPD_INT_W-1:0];
            `DPD_REG_INT_EN: s.int_en = pwdata[`DPD_INT_W-1:0];
            default: begin
            end
         endcase
      end
      // A new event beats a clear in the same cycle
      s.int_stat = s.int_stat | ev;
      s.irq = |(s.int_stat & s.int_en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.cs_n_d <= 1'b1;
      end else begin
         r <= s;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign spi_miso = r.miso;
   assign spi_miso_oe = r.miso_oe;
   assign power_down = r.dpd;
   assign irq = r.irq;

endmodule : dpd_top

// ### bench/dpd_assertions.sv
module dpd_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   input wire logic power_down
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_setup;
      psel && !penable;
   endsequence
   sequence apb_answer;
      pready ##1 !pready;
   endsequence
   chk_apb_answer: assert property (apb_setup |=> apb_answer)
      else $error("pready not one cycle after setup");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_pd_quiet: assert property (power_down |-> !spi_miso_oe)
      else $error("miso driven in power-down");
   chk_pd_hold: assert property ($rose(power_down) |=> power_down [*8])
      else $error("power-down left too soon");
   chk_pd_cs_high: assert property ($changed(power_down) |-> spi_cs_n)
      else $error("power state changed inside a frame");
   chk_oe_in_frame: assert property ($rose(spi_miso_oe) |-> !spi_cs_n && !spi_sclk)
      else $error("miso enabled outside a frame");
   chk_miso_on_fall: assert property ($changed(spi_miso) && $past(spi_miso_oe)
      |-> !spi_sclk)
      else $error("miso changed while sclk high");
   chk_oe_drops: assert property ($rose(spi_cs_n) |-> ##[0:6] !spi_miso_oe)
      else $error("miso enable held after deselect");
endmodule : dpd_assertions

bind dpd_top dpd_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .spi_sclk(spi_sclk),
   .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .power_down(power_down));

// ### bench/dpd_host_model.sv
`include "dpd_cfg.svh"
module dpd_host_model (
   input wire logic clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      spi_sclk = 1'h0;
      spi_cs_n = 1'h1;
      spi_mosi = 1'h0;
   end
   // Four pclk per level leaves margin over the two-flop synchroniser
   task automatic half();
      repeat (4) @(posedge clk);
   endtask : half
   task automatic frame(input logic [63:0] tx, input int nt, input int nr, output logic [31:0] rx);
      rx = 32'h0;
      spi_cs_n <= 1'h0;
      for (int i = 0; i < nt + nr; i++) begin
         if (i < nt) spi_mosi <= tx[63 - i];
         half();
         spi_sclk <= 1'h1;
         half();
         if (i >= nt) rx = {rx[30:0], spi_miso};
         spi_sclk <= 1'h0;
      end
      half();
      spi_cs_n <= 1'h1;
      // Flip the released line so a stale bit never looks valid
      spi_mosi <= ~spi_mosi;
      repeat (8) @(posedge clk);
   endtask : frame
   task automatic wake_wait();
      repeat (`DPD_WAKE_NS / `DPD_CLK_NS) @(posedge clk);
   endtask : wake_wait
endmodule : dpd_host_model

// ### bench/deep_power_down_and_busy_poll_bench.sv
module deep_power_down_and_busy_poll_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic sclk, cs_n, mosi, miso, oe, pd, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, rx, w;
   int fail_count = 0;
   int cmp_count = 0;
   logic [44:0] rows [6] = '{{12'h000, 32'h0, 1'h0}, {12'h004, 32'h0, 1'h0},
      {12'h008, 32'h0, 1'h0}, {12'h010, 32'h0, 1'h0}, {12'h014, 32'h0, 1'h0},
      {12'h018, 32'h0, 1'h1}};
   dpd_top i_dpd_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
      .spi_miso_oe(oe), .power_down(pd), .irq(irq));
   dpd_host_model i_dpd_host_model (.clk(pclk), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso));
   initial begin
      pclk = 1'h0;
      forever #50 pclk = ~pclk;
   end
   task report_and_stop();
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      for (int n = 0; n <= 20; n++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
         if (n == 20) begin
            fail_count++;
            report_and_stop();
         end
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task wait_pd(input logic v);
      for (int n = 0; n < 40 && pd !== v; n++) @(posedge pclk);
      if (pd !== v) begin
         fail_count++;
         report_and_stop();
      end
   endtask : wait_pd
   task sr(input logic b);
      i_dpd_host_model.frame({8'h05, 56'h0}, 8, 8, rx);
      cmp(rx, {31'h0, b});
   endtask : sr
   initial begin
      presetn = 1'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      cmp({30'h0, pd, irq}, 32'h0);
      foreach (rows[i]) begin
         apb(1'h0, rows[i][44:33], 32'h0);
         cmp(r, rows[i][32:1]);
         cmp({31'h0, e}, {31'h0, rows[i][0]});
      end
      i_dpd_host_model.frame({8'h5a, 24'h34, 32'h0}, 40, 32, rx);
      w = {1'h0, 8'hb9, 8'hab, 2'h1, 5'h02, 4'hf, 2'h1, 2'h3};
      cmp(rx, {w[7:0], w[15:8], w[23:16], w[31:24]});
      sr(1'h0);
      apb(1'h1, 12'h000, 32'h1);
      sr(1'h1);
      apb(1'h1, 12'h000, 32'h0);
      // A ninth clock must cancel the entry
      i_dpd_host_model.frame({8'hb9, 56'h0}, 9, 0, rx);
      cmp({31'h0, pd}, 32'h0);
      i_dpd_host_model.frame({8'hb9, 56'h0}, 8, 0, rx);
      wait_pd(1'h1);
      cmp({31'h0, irq}, 32'h0);
      apb(1'h1, 12'h010, 32'hf);
      i_dpd_host_model.frame({8'h05, 56'h0}, 8, 8, rx);
      apb(1'h0, 12'h008, 32'h0);
      cmp(r, 32'h9);
      cmp({31'h0, irq}, 32'h1);
      apb(1'h1, 12'h00c, 32'hf);
      apb(1'h0, 12'h008, 32'h0);
      cmp(r, 32'h0);
      cmp({31'h0, irq}, 32'h0);
      i_dpd_host_model.frame({8'hab, 56'h0}, 8, 0, rx);
      wait_pd(1'h0);
      apb(1'h0, 12'h004, 32'h0);
      cmp(r, 32'h6);
      i_dpd_host_model.wake_wait();
      sr(1'h0);
      apb(1'h0, 12'h008, 32'h0);
      cmp(r, 32'h6);
      apb(1'h0, 12'h014, 32'h0);
      cmp(r, 32'h05);
      // A reset in mid-run must leave power-down as well
      i_dpd_host_model.frame({8'hb9, 56'h0}, 8, 0, rx);
      wait_pd(1'h1);
      presetn <= 1'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      cmp({30'h0, pd, irq}, 32'h0);
      apb(1'h0, 12'h014, 32'h0);
      cmp(r, 32'h0);
      report_and_stop();
   end
endmodule : deep_power_down_and_busy_poll_bench
